//--- hw/fbd_dmac.sv
// four-channel byte dma controller on a processor bus.
// assumes all pins synchronous to sys_clk, mem_phase_clk a sampled level.
// Operation
// (RULE_01) fifteen registers: address and count per channel, controls.
// (RULE_02) channel control sets direction, mode and address step direction.
// (RULE_03) each channel runs clock-stretch steal, halt steal or halt burst.
// (RULE_04) control register shows read-only busy and done bits.
// (RULE_05) priority control: per-channel request enables, fixed or rotating.
// (RULE_06) count zero gives block end and interrupt gated by enables.
// (RULE_07) chained channel reloads from channel 3 at count zero.
// (RULE_08) winning request raises bus request; after grant strobe, drive bus.
// (RULE_09) reset clears all but address and count registers.
// (RULE_10) software programs a channel before enabling its request.
// (RULE_11) stretch mode drives stretch request, one byte, then releases; here the request is held only until grant, before the byte moves.
// (RULE_12) clock driver answers stretch with grant and floats the processor.
// (RULE_13) halt steal drives halt, takes bus available as grant, one byte.
// (RULE_14) halt burst holds processor until count reaches zero.
// (RULE_15) data drivers on only during processor register reads.
// (RULE_16) select pin drives high channel bit only in four-channel dma.
// (RULE_17) low address pins select registers, or carry the dma address.
// (RULE_18) enabled interrupt drives shared output low after the last byte.
// (RULE_19) selected read returns a register; selected write stores it.
// (RULE_20) dma read/write follows control bit 0 of serviced channel.
// (RULE_21) system qualifies select with valid memory, open collector.
// (RULE_22) high request sampled on memory-phase rise; best channel served.
// (RULE_23) channel number encoded on high and low acknowledge bits.
// (RULE_24) everything is timed by the non-stretched memory-phase clock.
// (RULE_25) each byte steps address by one and decrements count.
`timescale 1ns/100ps
`default_nettype none
`include "fbd_params.svh"
module fbd_dmac (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic external_reset_n,
  input wire logic mem_phase_clk,
  input wire logic four_channel_mode,
  input wire logic [3:0] channel_transfer_request,
  input wire logic bus_grant_in,
  output logic clock_stretch_request_n,
  output logic cpu_halt_request_n,
  input wire logic select_or_channel_bit_hi_in,
  output logic select_or_channel_bit_hi_out,
  output logic select_or_channel_bit_hi_oe,
  output logic channel_bit_lo,
  output logic transfer_strobe_n,
  output logic valid_memory_qualifier,
  output logic irq_block_end_n,
  input wire logic [4:0] reg_sel_in,
  output logic [15:0] addr_out,
  output logic addr_oe,
  input wire logic rw_in,
  output logic rw_out,
  output logic rw_oe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic log_valid,
  input wire logic log_ready,
  output logic [`FBD_LOG_W-1:0] log_data
);
  fbd_pkg::fbd_regs_t q, n;
  logic p2_rise, p2_fall, dma, sel, cpu_wr, last_byte, irq_flag;
  logic arb_any, push, push_ready, burst, three_state_stretch, halt_mode;
  logic [1:0] win;
  logic [3:0] elig;
  logic [15:0] cur_adr, cur_cnt;
  logic [7:0] cur_ctl;
  logic [`FBD_LOG_W-1:0] push_data;

  // edges of the memory-phase clock, never the stretched cpu clock
  assign p2_rise = mem_phase_clk && !q.p2; // RULE_24
  assign p2_fall = !mem_phase_clk && q.p2; // RULE_24

  assign cur_adr = q.adr[q.ch];
  assign cur_cnt = q.cnt[q.ch];
  assign cur_ctl = q.ctl[q.ch];
  // tsc wins over burst so that exactly one mode is in force
  assign three_state_stretch = cur_ctl[`FBD_CTL_TSC]; // RULE_03
  assign burst = cur_ctl[`FBD_CTL_BURST] && !three_state_stretch; // RULE_03
  assign halt_mode = !three_state_stretch;
  assign dma = q.st == fbd_pkg::FBD_XFER || q.st == fbd_pkg::FBD_WAIT;
  assign last_byte = cur_cnt == `FBD_LAST_BYTE_CNT;

  // while the pin carries the channel bit it cannot select the chip
  assign sel = !select_or_channel_bit_hi_in && !dma;
  assign cpu_wr = sel && !rw_in && p2_fall; // RULE_19

  // a channel with nothing left to move never competes
  for (genvar c = 0; c < 4; c++) begin : g_elig
    assign elig[c] = channel_transfer_request[c] && q.pri[c] &&
                     q.cnt[c] != 16'h0000; // RULE_05
  end

  fbd_arb u_arb (
    .req(elig),
    .rotate(q.pri[`FBD_PRI_ROT]),
    .last(q.last),
    .any(arb_any),
    .win(win)
  );

  assign push = q.st == fbd_pkg::FBD_XFER && p2_fall;
  assign push_data = {last_byte, q.ch, cur_adr};

  fbd_buf2 u_log (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(log_valid),
    .out_ready(log_ready),
    .out_data(log_data)
  );

  assign irq_flag = |(q.done & q.ien[3:0]); // RULE_06

  always_comb begin
    n = q;
    n.p2 = mem_phase_clk;

    // register writes from the processor
    if (cpu_wr) begin
      if (reg_sel_in < `FBD_OFS_CTL_BASE) begin // RULE_01
        if (!reg_sel_in[1] && !reg_sel_in[0]) begin
          n.adr[reg_sel_in[3:2]][15:8] = data_in;
        end else if (!reg_sel_in[1]) begin
          n.adr[reg_sel_in[3:2]][7:0] = data_in;
        end else if (!reg_sel_in[0]) begin
          n.cnt[reg_sel_in[3:2]][15:8] = data_in;
        end else begin
          n.cnt[reg_sel_in[3:2]][7:0] = data_in;
        end
      end else if (reg_sel_in < `FBD_OFS_PRI) begin
        n.ctl[reg_sel_in[1:0]] = data_in & `FBD_CTL_WMASK; // RULE_02
        n.done[reg_sel_in[1:0]] = 1'b0;
      end else if (reg_sel_in == `FBD_OFS_PRI) begin
        n.pri = data_in; // RULE_05
      end else if (reg_sel_in == `FBD_OFS_IEN) begin
        n.ien = data_in & 8'h0f;
      end else if (reg_sel_in == `FBD_OFS_CHN) begin
        n.chn = data_in & 8'h07;
      end
    end

    // read data is prepared every cycle and held in a flop
    n.rdata = `FBD_RST_BYTE;
    if (reg_sel_in < `FBD_OFS_CTL_BASE) begin
      if (!reg_sel_in[1] && !reg_sel_in[0]) begin
        n.rdata = q.adr[reg_sel_in[3:2]][15:8];
      end else if (!reg_sel_in[1]) begin
        n.rdata = q.adr[reg_sel_in[3:2]][7:0];
      end else if (!reg_sel_in[0]) begin
        n.rdata = q.cnt[reg_sel_in[3:2]][15:8];
      end else begin
        n.rdata = q.cnt[reg_sel_in[3:2]][7:0];
      end
    end else if (reg_sel_in < `FBD_OFS_PRI) begin
      n.rdata = q.ctl[reg_sel_in[1:0]];
      n.rdata[`FBD_CTL_DONE] = q.done[reg_sel_in[1:0]]; // RULE_04
      n.rdata[`FBD_CTL_BUSY] = q.st != fbd_pkg::FBD_IDLE &&
                               q.ch == reg_sel_in[1:0]; // RULE_04
    end else if (reg_sel_in == `FBD_OFS_PRI) begin
      n.rdata = q.pri;
    end else if (reg_sel_in == `FBD_OFS_IEN) begin
      n.rdata = q.ien;
      n.rdata[`FBD_IEN_FLAG] = irq_flag; // RULE_06
    end else if (reg_sel_in == `FBD_OFS_CHN) begin
      n.rdata = q.chn;
    end

    case (q.st)
      fbd_pkg::FBD_IDLE: begin
        // requests are looked at only on the phase rise
        if (p2_rise && arb_any && push_ready) begin // RULE_22
          n.ch = win;
          n.st = fbd_pkg::FBD_REQ; // RULE_08
        end
      end
      fbd_pkg::FBD_REQ: begin
        if (p2_rise && bus_grant_in) begin
          n.st = fbd_pkg::FBD_XFER; // RULE_08
        end
      end
      fbd_pkg::FBD_XFER: begin
        if (p2_fall) begin
          if (cur_ctl[`FBD_CTL_DEC]) begin
            n.adr[q.ch] = cur_adr - 16'h0001; // RULE_25
          end else begin
            n.adr[q.ch] = cur_adr + 16'h0001; // RULE_25
          end
          n.cnt[q.ch] = cur_cnt - 16'h0001; // RULE_25
          if (last_byte) begin
            n.done[q.ch] = 1'b1; // RULE_06
            if (q.chn[`FBD_CHN_EN] &&
                q.chn[`FBD_CHN_SEL_LO +: 2] == q.ch) begin
              n.adr[q.ch] = q.adr[3]; // RULE_07
              n.cnt[q.ch] = q.cnt[3]; // RULE_07
            end
            n.last = q.ch;
            n.st = fbd_pkg::FBD_IDLE; // RULE_14
          end else if (burst) begin
            // later burst bytes sample the request on the phase fall
            if (channel_transfer_request[q.ch] && q.pri[q.ch] &&
                push_ready) begin
              n.st = fbd_pkg::FBD_XFER; // RULE_14
            end else begin
              n.st = fbd_pkg::FBD_WAIT; // RULE_14
            end
          end else begin
            n.last = q.ch;
            n.st = fbd_pkg::FBD_IDLE; // RULE_11 RULE_13
          end
        end
      end
      fbd_pkg::FBD_WAIT: begin
        // processor stays halted while a burst waits for its peripheral
        if (!q.pri[q.ch]) begin
          n.last = q.ch;
          n.st = fbd_pkg::FBD_IDLE;
        end else if (p2_fall && channel_transfer_request[q.ch] &&
                     push_ready) begin
          n.st = fbd_pkg::FBD_XFER; // RULE_14
        end
      end
      default: begin
        n.st = fbd_pkg::FBD_IDLE;
      end
    endcase

    // external reset spares address and count contents
    if (!external_reset_n) begin // RULE_09
      n.st = fbd_pkg::FBD_IDLE;
      n.ch = 2'h0;
      n.last = 2'h0;
      n.ctl = '0;
      n.done = 4'h0;
      n.pri = `FBD_RST_BYTE;
      n.ien = `FBD_RST_BYTE;
      n.chn = `FBD_RST_BYTE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // bus requests follow the mode of the channel in service
  assign clock_stretch_request_n =
    !(q.st == fbd_pkg::FBD_REQ && three_state_stretch); // RULE_11
  assign cpu_halt_request_n =
    !(q.st != fbd_pkg::FBD_IDLE && halt_mode); // RULE_13 RULE_14
  assign transfer_strobe_n = q.st != fbd_pkg::FBD_XFER; // RULE_08
  assign valid_memory_qualifier = q.st == fbd_pkg::FBD_XFER; // RULE_08
  assign addr_out = cur_adr; // RULE_17
  assign addr_oe = dma; // RULE_17
  assign rw_out = cur_ctl[`FBD_CTL_DIR]; // RULE_20
  assign rw_oe = dma; // RULE_20
  assign channel_bit_lo = q.ch[0]; // RULE_23
  assign select_or_channel_bit_hi_out = q.ch[1]; // RULE_23
  assign select_or_channel_bit_hi_oe = dma && four_channel_mode; // RULE_16
  // drivers stay off in dma; a stale read flop never reaches the bus
  assign data_oe = sel && rw_in && mem_phase_clk; // RULE_15 RULE_19
  assign data_out = q.rdata;
  // block end marks the last byte, the interrupt holds it low afterwards
  assign irq_block_end_n =
    !((q.st == fbd_pkg::FBD_XFER && last_byte) || irq_flag); // RULE_18

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  data_off_dma_a: assert property (dma |-> !data_oe) // RULE_15
    else $error("data drivers on during dma");
  one_request_a: assert property (
    !(!clock_stretch_request_n && !cpu_halt_request_n)) // RULE_03
    else $error("both bus requests active");
  addr_drive_a: assert property (
    dma |-> addr_oe && rw_oe && addr_out == q.adr[q.ch]) // RULE_17
    else $error("dma address not driven from channel register");
  rw_dir_a: assert property (
    dma |-> rw_out == q.ctl[q.ch][`FBD_CTL_DIR]) // RULE_20
    else $error("dma read/write does not follow control bit 0");
  hi_bit_drive_a: assert property (
    select_or_channel_bit_hi_oe |-> four_channel_mode && dma) // RULE_16
    else $error("channel high bit driven outside four-channel dma");
  count_step_a: assert property (
    push && !last_byte |=> cur_cnt == $past(cur_cnt) - 16'h0001) // RULE_25
    else $error("byte count did not step by one");
  ext_reset_a: assert property (
    !external_reset_n |=> q.pri == 8'h00 && q.ien == 8'h00 &&
    q.chn == 8'h00 && q.st == fbd_pkg::FBD_IDLE) // RULE_09
    else $error("external reset left control state set");
  grant_wait_a: assert property (
    q.st == fbd_pkg::FBD_REQ && !bus_grant_in |=>
    q.st != fbd_pkg::FBD_XFER) // RULE_08
    else $error("transfer began without grant");
  irq_out_a: assert property (irq_flag |-> !irq_block_end_n) // RULE_18
    else $error("enabled interrupt not shown on output");
  burst_hold_a: assert property (
    push && burst && !last_byte |=> !cpu_halt_request_n [*2]) // RULE_14
    else $error("burst released processor before count zero");
  done_set_a: assert property (
    push && last_byte |=> q.done[$past(q.ch)]) // RULE_06
    else $error("done flag not set at block end");
endmodule
`default_nettype wire

//--- hw/fbd_params.svh
// constants of the four-channel byte dma controller: register offsets,
// field positions and reset values.
// assumes the including file uses the fbd_ prefix for its own names.
`ifndef FBD_PARAMS_SVH
`define FBD_PARAMS_SVH

// 5-bit register select offsets
`define FBD_OFS_CTL_BASE 5'h10
`define FBD_OFS_PRI 5'h14
`define FBD_OFS_IEN 5'h15
`define FBD_OFS_CHN 5'h16

// channel control fields
`define FBD_CTL_DIR 0
`define FBD_CTL_TSC 1
`define FBD_CTL_BURST 2
`define FBD_CTL_DEC 3
`define FBD_CTL_WMASK 8'h0f
`define FBD_CTL_BUSY 6
`define FBD_CTL_DONE 7

// priority, interrupt and chain fields
`define FBD_PRI_ROT 7
`define FBD_IEN_FLAG 7
`define FBD_CHN_EN 0
`define FBD_CHN_SEL_LO 1

// value after reset and count of the last byte
`define FBD_RST_BYTE 8'h00
`define FBD_LAST_BYTE_CNT 16'h0001

// completion record: block end, channel, address
`define FBD_LOG_W 19
`define FBD_BUF_DEPTH 2

`endif

//--- hw/fbd_pkg.sv
// types of the four-channel byte dma controller.
// assumes fbd_params.svh is on the include path.
`include "fbd_params.svh"
package fbd_pkg;

  // gray along idle, request, transfer
  typedef enum logic [1:0] {
    FBD_IDLE = 2'b00,
    FBD_REQ = 2'b01,
    FBD_XFER = 2'b11,
    FBD_WAIT = 2'b10
  } fbd_state_t;

  typedef struct packed {
    fbd_state_t st;
    logic [1:0] ch;
    logic [1:0] last;
    logic [3:0][15:0] adr;
    logic [3:0][15:0] cnt;
    logic [3:0][7:0] ctl;
    logic [3:0] done;
    logic [7:0] pri;
    logic [7:0] ien;
    logic [7:0] chn;
    logic p2;
    logic [7:0] rdata;
  } fbd_regs_t;

endpackage

//--- hw/fbd_arb.sv
// request arbiter with fixed or rotating order.
// assumes requests are already masked by enable and nonzero count.
`timescale 1ns/100ps
`default_nettype none
module fbd_arb (
  input wire logic [3:0] req,
  input wire logic rotate,
  input wire logic [1:0] last,
  output logic any,
  output logic [1:0] win
);
  logic [3:0][1:0] idx;
  logic [3:0] hit;

  // slot g holds the channel tried g-th; rotating starts after last
  genvar g;
  for (g = 0; g < 4; g++) begin : g_slot
    assign idx[g] = rotate ? 2'(last + 2'(g + 1)) : 2'(g);
    assign hit[g] = req[idx[g]];
  end

  always_comb begin
    any = |hit;
    win = idx[3];
    for (int i = 3; i >= 0; i--) begin
      if (hit[i]) begin
        win = idx[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/fbd_buf2.sv
// two-entry buffer with valid and ready on both sides.
// assumes one clock; a full buffer drops in_ready, never a word.
`timescale 1ns/100ps
`default_nettype none
`include "fbd_params.svh"
module fbd_buf2 #(
  parameter int W = `FBD_LOG_W,
  parameter int D = `FBD_BUF_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [$clog2(D)-1:0] wp;
    logic [$clog2(D)-1:0] rp;
    logic [$clog2(D+1)-1:0] cnt;
  } fbd_buf_t;

  fbd_buf_t q, n;
  logic push, pop;

  assign in_ready = q.cnt != D[$clog2(D+1)-1:0];
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp = q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = q.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  no_overfill_a: assert property (q.cnt <= D) // ok
    else $error("buffer holds more words than its depth");
endmodule
`default_nettype wire

//--- tb/fbd_partner.sv
// processor side of the dma controller: memory phase clock and bus grant.
// assumes requests are settled shortly after each rising sys_clk edge.
`timescale 1ns/100ps
`default_nettype none
module fbd_partner (
  input wire logic sys_clk,
  input wire logic clock_stretch_request_n,
  input wire logic cpu_halt_request_n,
  input wire logic [3:0] grant_delay,
  output logic mem_phase_clk,
  output logic bus_grant_in
);
  logic [2:0] div;
  logic [3:0] wait_cnt;

  initial begin
    div = 3'h0;
    wait_cnt = 4'h0;
    mem_phase_clk = 1'b0;
    bus_grant_in = 1'b0;
  end

  // the memory clock runs free and is never stretched, 8 sys_clk per cycle
  always @(posedge sys_clk) begin
    #1;
    div = div + 3'h1;
    mem_phase_clk = div[2];
    if (clock_stretch_request_n && cpu_halt_request_n) begin
      bus_grant_in = 1'b0;
      wait_cnt = 4'h0;
    end else if (div == 3'h0) begin
      // grant only at the phase-one rise, optionally some cycles late
      if (wait_cnt >= grant_delay)
        bus_grant_in = 1'b1;
      else
        wait_cnt = wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench of the four-channel byte dma controller.
// assumes fbd_params.svh on the include path and fbd_partner compiled.
`timescale 1ns/100ps
`default_nettype none
`include "fbd_params.svh"
module tb_top;
  logic sys_clk, rst, ext_rst_n, fcm, cs_n, rw, log_ready;
  logic [3:0] req, gdly;
  logic [4:0] rs;
  logic [7:0] din, dout, dbus;
  logic mpc, grant, stretch_n, halt_n, sel_i, sel_o, sel_oe, ch_lo;
  logic strobe_n, vmq, irq_n, addr_oe, rw_o, rw_oe, rw_w, data_oe;
  logic log_valid, mon, ehalt, erw;
  logic [15:0] addr_o, eadr, estep, pa;
  logic [`FBD_LOG_W-1:0] log_data;
  logic [1:0] ech;
  logic ps = 1'b1;
  logic ph = 1'b1;
  logic pst = 1'b1;
  int errors, n_checks, n_bytes, n_hrise, n_sfall;

  // open-collector select with no pull-up: released while the dut drives
  assign sel_i = sel_oe ? sel_o : cs_n;
  assign rw_w = rw_oe ? rw_o : rw;
  assign dbus = data_oe ? dout : din;

  fbd_partner u_partner (.sys_clk(sys_clk),
    .clock_stretch_request_n(stretch_n), .cpu_halt_request_n(halt_n),
    .grant_delay(gdly), .mem_phase_clk(mpc), .bus_grant_in(grant));

  fbd_dmac u_dut (.sys_clk(sys_clk), .rst(rst),
    .external_reset_n(ext_rst_n), .mem_phase_clk(mpc),
    .four_channel_mode(fcm), .channel_transfer_request(req),
    .bus_grant_in(grant), .clock_stretch_request_n(stretch_n),
    .cpu_halt_request_n(halt_n), .select_or_channel_bit_hi_in(sel_i),
    .select_or_channel_bit_hi_out(sel_o),
    .select_or_channel_bit_hi_oe(sel_oe), .channel_bit_lo(ch_lo),
    .transfer_strobe_n(strobe_n), .valid_memory_qualifier(vmq),
    .irq_block_end_n(irq_n), .reg_sel_in(rs), .addr_out(addr_o),
    .addr_oe(addr_oe), .rw_in(rw_w), .rw_out(rw_o), .rw_oe(rw_oe),
    .data_in(dbus), .data_out(dout), .data_oe(data_oe),
    .log_valid(log_valid), .log_ready(log_ready), .log_data(log_data));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic bad(input string m);
    errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask

  task automatic to(input string m);
    bad(m);
    results;
  endtask

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
      bad(m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic phase(input logic lvl);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (mpc !== lvl && i < 20);
    #1;
    if (i >= 20)
      to("phase clock stuck");
  endtask

  // a write is taken at the fall of the memory phase clock
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cs_n = 1'b0;
    rw = 1'b0;
    rs = a;
    din = d;
    phase(1'b1);
    phase(1'b0);
    cs_n = 1'b1;
    rw = 1'b1;
    cyc(1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    cs_n = 1'b0;
    rw = 1'b1;
    rs = a;
    // land on the phase rise so the buffers stand for the whole high half
    phase(1'b0);
    phase(1'b1);
    #2;
    chk(data_oe === 1'b1 && dout === e, "register read");
    cyc(1);
    cs_n = 1'b1;
    cyc(1);
  endtask

  task automatic prog(input logic [1:0] c, input logic [7:0] ctl,
                      input logic [15:0] a, n);
    wr({1'b0, c, 2'h0}, a[15:8]);
    wr({1'b0, c, 2'h1}, a[7:0]);
    wr({1'b0, c, 2'h2}, n[15:8]);
    wr({1'b0, c, 2'h3}, n[7:0]);
    wr(`FBD_OFS_CTL_BASE | {3'h0, c}, ctl);
  endtask

  task automatic pop(input logic [`FBD_LOG_W-1:0] e);
    int i;
    log_ready = 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (log_valid !== 1'b1 && i < 400);
    chk(log_data === e, "completion record");
    #1;
    log_ready = 1'b0;
    if (i >= 400)
      to("no completion record");
    cyc(1);
  endtask

  // the peripheral withdraws its request once acknowledged
  task automatic drop_on_strobe;
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (strobe_n !== 1'b0 && i < 400);
    #1;
    req = 4'h0;
    if (i >= 400)
      to("no strobe");
  endtask

  task automatic setx(input logic [1:0] c, input logic r, h,
                      input logic [15:0] a, s);
    ech = c;
    erw = r;
    ehalt = h;
    eadr = a;
    estep = s;
    mon = 1'b1;
    n_bytes = 0;
    n_hrise = 0;
    n_sfall = 0;
  endtask

  always @(posedge sys_clk) begin
    #3;
    if (!rst) begin
      if (sel_i !== 1'b0 || rw_w !== 1'b1)
        chk(data_oe === 1'b0, "data bus driven");
      // a burst holds the strobe low, so a new address marks a new byte
      if (strobe_n === 1'b0 && (ps || addr_o !== pa)) begin
        n_bytes++;
        if (mon) begin
          chk({addr_oe, rw_oe, sel_oe, sel_o, ch_lo, rw_o, vmq} ===
              {2'b11, fcm, ech, erw, 1'b1}, "dma pins");
          chk(addr_o === eadr, "dma address");
          chk(halt_n === ehalt, "halt request");
          eadr = eadr + estep;
        end
      end
      if (halt_n === 1'b1 && !ph)
        n_hrise++;
      if (stretch_n === 1'b0 && pst)
        n_sfall++;
    end
    ps = strobe_n;
    pa = addr_o;
    ph = halt_n;
    pst = stretch_n;
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    to("run time limit");
  end

  initial begin
    rst = 1'b1;
    ext_rst_n = 1'b1;
    fcm = 1'b1;
    cs_n = 1'b1;
    rw = 1'b1;
    log_ready = 1'b0;
    req = 4'h0;
    gdly = 4'h0;
    rs = 5'h00;
    din = 8'h00;
    mon = 1'b0;
    errors = 0;
    n_checks = 0;
    cyc(16);
    rst = 1'b0;
    wr(5'h17, 8'hff);
    for (int a = 16; a < 24; a++)
      rd(5'(a), 8'h00);
    prog(2'h0, 8'hff, 16'ha55a, 16'h0102);
    rd(5'h00, 8'ha5);
    rd(5'h03, 8'h02);
    rd(`FBD_OFS_CTL_BASE, 8'h0f);
    // halt steal, memory read, two bytes
    prog(2'h0, 8'h01, 16'h1234, 16'h0002);
    wr(`FBD_OFS_IEN, 8'h01);
    setx(2'h0, 1'b1, 1'b0, 16'h1234, 16'h0001);
    req = 4'h1;
    wr(`FBD_OFS_PRI, 8'h01);
    pop({1'b0, 2'h0, 16'h1234});
    pop({1'b1, 2'h0, 16'h1235});
    req = 4'h0;
    rd(`FBD_OFS_CTL_BASE, 8'h81);
    rd(`FBD_OFS_IEN, 8'h81);
    chk(irq_n === 1'b0 && n_hrise == 2, "irq or halt");
    rd(5'h01, 8'h36);
    rd(5'h03, 8'h00);
    wr(`FBD_OFS_CTL_BASE, 8'h00);
    chk(irq_n === 1'b1, "irq not cleared");
    // clock-stretch steal, decrement, memory write, two-channel mode
    fcm = 1'b0;
    prog(2'h1, 8'h0a, 16'h0100, 16'h0002);
    setx(2'h1, 1'b0, 1'b1, 16'h0100, 16'hffff);
    req = 4'h2;
    wr(`FBD_OFS_PRI, 8'h02);
    pop({1'b0, 2'h1, 16'h0100});
    pop({1'b1, 2'h1, 16'h00ff});
    chk(n_sfall == 2 && n_hrise == 0, "stretch steal");
    // halt burst with a slow grant
    fcm = 1'b1;
    gdly = 4'h3;
    prog(2'h2, 8'h05, 16'h2000, 16'h0003);
    setx(2'h2, 1'b1, 1'b0, 16'h2000, 16'h0001);
    req = 4'h4;
    wr(`FBD_OFS_PRI, 8'h04);
    pop({1'b0, 2'h2, 16'h2000});
    pop({1'b0, 2'h2, 16'h2001});
    pop({1'b1, 2'h2, 16'h2002});
    chk(n_hrise == 1 && n_bytes == 3, "burst halt");
    // chained reload from channel 3
    gdly = 4'h0;
    prog(2'h3, 8'h00, 16'h4000, 16'h0005);
    prog(2'h1, 8'h00, 16'h0200, 16'h0001);
    wr(`FBD_OFS_CHN, 8'h03);
    setx(2'h1, 1'b0, 1'b0, 16'h0200, 16'h0001);
    req = 4'h2;
    wr(`FBD_OFS_PRI, 8'h02);
    drop_on_strobe;
    pop({1'b1, 2'h1, 16'h0200});
    rd(5'h04, 8'h40);
    rd(5'h07, 8'h05);
    wr(`FBD_OFS_CHN, 8'h00);
    // fixed then rotating order
    mon = 1'b0;
    prog(2'h0, 8'h00, 16'h3000, 16'h0001);
    prog(2'h2, 8'h00, 16'h3100, 16'h0001);
    req = 4'h5;
    wr(`FBD_OFS_PRI, 8'h05);
    pop({1'b1, 2'h0, 16'h3000});
    pop({1'b1, 2'h2, 16'h3100});
    prog(2'h1, 8'h00, 16'h3200, 16'h0001);
    prog(2'h3, 8'h00, 16'h3300, 16'h0001);
    req = 4'ha;
    wr(`FBD_OFS_PRI, 8'h8a);
    pop({1'b1, 2'h3, 16'h3300});
    pop({1'b1, 2'h1, 16'h3200});
    // a full completion buffer holds off the third byte
    prog(2'h0, 8'h00, 16'h5000, 16'h0003);
    setx(2'h0, 1'b0, 1'b0, 16'h5000, 16'h0001);
    req = 4'h1;
    wr(`FBD_OFS_PRI, 8'h01);
    cyc(120);
    chk(n_bytes == 2 && log_valid === 1'b1, "buffer stall");
    pop({1'b0, 2'h0, 16'h5000});
    pop({1'b0, 2'h0, 16'h5001});
    pop({1'b1, 2'h0, 16'h5002});
    req = 4'h0;
    // external reset keeps address and count only
    ext_rst_n = 1'b0;
    cyc(2);
    ext_rst_n = 1'b1;
    rd(`FBD_OFS_CTL_BASE, 8'h00);
    rd(`FBD_OFS_PRI, 8'h00);
    rd(`FBD_OFS_IEN, 8'h00);
    rd(5'h01, 8'h03);
    results;
  end
endmodule
`default_nettype wire
